// [src/inertial_event_irq_two_defines.svh]
`ifndef INERTIAL_EVENT_IRQ_TWO_DEFINES_SVH
`define INERTIAL_EVENT_IRQ_TWO_DEFINES_SVH

// register indexes; the bus byte address is 4 * index
`define IEV_IDX_CONFIG     8'h34
`define IEV_IDX_SOURCE     8'h35
`define IEV_IDX_THRESHOLD  8'h36
`define IEV_IDX_DURATION   8'h37
`define IEV_IDX_IRQ_STATUS 8'h38
`define IEV_IDX_IRQ_MASK   8'h39
`define IEV_IDX_CONTROL    8'h3A

// configuration fields
`define IEV_CFG_COMBINE    7
`define IEV_CFG_SIXDIR     6
`define IEV_SRC_ACTIVE     6
`define IEV_FIELD_MSB      6
`define IEV_CTRL_LATCH     0

// flag groups in source order {zh, zl, yh, yl, xh, xl}
`define IEV_HIGH_FLAGS     6'h2A
`define IEV_LOW_FLAGS      6'h15

// duration counter saturates here rather than wrapping to zero
`define IEV_CNT_MAX        7'h7F

// reset values
`define IEV_RST_BYTE       8'h00
`define IEV_RST_FIELD      7'h00
`define IEV_RST_FLAGS      6'h00
`define IEV_RST_DIV        16'h0000

// interrupt status bits
`define IEV_IRQ_EVENT      0
`define IEV_IRQ_WIDTH      1

// data rate divider default (odr tick every N clocks)
`define IEV_ODR_DIV_DEF    16'h0064

`endif

// [src/inertial_event_irq_two_pkg.sv]
package inertial_event_irq_two_pkg;
   typedef enum logic [1:0] {
      MODE_OR   = 2'b00,
      MODE_MOVE = 2'b01,
      MODE_AND  = 2'b10,
      MODE_POS  = 2'b11
   } combine_mode_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_DONE = 2'b01
   } bus_state_t;
endpackage

// [src/axis_compare.sv]
`timescale 1ns/1ns
`default_nettype none
// per-axis magnitude compare against threshold; result registered
module axis_compare #(
   parameter int AXES  = 3,
   parameter int WIDTH = 16
) (
   input  wire logic                  sys_clk_i,
   input  wire logic                  rst_n_i,
   input  wire logic [AXES*WIDTH-1:0] accel_i,
   input  wire logic [6:0]            threshold_i,
   output logic      [AXES-1:0]       high_o,
   output logic      [AXES-1:0]       low_o
);
   // elaboration guard: the threshold needs eight bits of room
   if (WIDTH < 8) begin : g_bad_width
      $error("axis_compare: WIDTH below 8");
   end

   // compare the signed axis value with the unsigned threshold placed in the top bits
   genvar g;
   generate
      for (g = 0; g < AXES; g = g + 1) begin : g_axis
         logic signed [WIDTH-1:0] v;
         logic signed [WIDTH-1:0] t;
         assign v = accel_i[g*WIDTH +: WIDTH];
         assign t = {1'b0, threshold_i, {(WIDTH-8){1'b0}}};
         always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               high_o[g] <= 1'b0;
               low_o[g]  <= 1'b0;
            end else begin
               high_o[g] <= (v > t);
               low_o[g]  <= (v < -t);
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// [src/inertial_event_irq_two.sv]
// Notes on behaviour
// - six-dir off: select chooses OR or AND
// - six-dir on: select chooses movement or position
// - high enable per axis gates over-threshold
// - low enable per axis gates under-threshold
// - active flag set on event, resets zero
// - six source flags, top bit zero
// - source register ignores writes
// - source read clears active and pin
// - latched mode freezes flags until read
// - seven-bit threshold, top bit zero
// - seven-bit minimum duration, resets zero
// - duration counts output-data-rate ticks
`timescale 1ns/1ns
`default_nettype none
`include "inertial_event_irq_two_defines.svh"
module inertial_event_irq_two #(
   parameter int        WIDTH   = 16,
   parameter logic [15:0] ODR_DIV = `IEV_ODR_DIV_DEF
) (
   input  wire logic              sys_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic [3*WIDTH-1:0] accel_i,
   input  wire logic [7:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output logic      [31:0]       avs_readdata,
   output logic                   avs_waitrequest,
   output logic                   event_pin_o,
   output logic                   irq_o
);
   // elaboration guard: a zero divider would wrap and tick only every 65536 clocks
   if (ODR_DIV == 16'h0000) begin : g_bad_div
      $error("ODR_DIV must be nonzero");
   end

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0]                          cfg;
      logic [6:0]                          ths;
      logic [6:0]                          dur;
      logic                                latch;
      logic [5:0]                          flags;
      logic                                active;
      logic [6:0]                          cnt;
      logic [15:0]                         div;
      logic [`IEV_IRQ_WIDTH-1:0]           irq_st;
      logic [`IEV_IRQ_WIDTH-1:0]           irq_mk;
      logic [31:0]                         rdata;
      inertial_event_irq_two_pkg::bus_state_t bst;
      logic [5:0]                          pos_q;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic [2:0] hi;
   logic [2:0] lo;

   // magnitude compares per axis, one cycle of latency
   axis_compare #(
      .AXES  (3),
      .WIDTH (WIDTH)
   ) u_cmp (
      .sys_clk_i   (sys_clk_i),
      .rst_n_i     (rst_n_i),
      .accel_i     (accel_i),
      .threshold_i (s_q.ths),
      .high_o      (hi),
      .low_o       (lo)
   );

   ////////////////////////////////////////////////////////////////////////
   logic        odr_tick;
   logic [5:0]  raw;
   logic [5:0]  en;
   logic        cond;
   logic        fire;
   logic        acc;
   logic [7:0]  idx;
   logic        rd_src;
   logic [5:0]  pos_now;
   inertial_event_irq_two_pkg::combine_mode_t mode;

   // source order {zh, zl, yh, yl, xh, xl}
   assign raw  = {hi[2], lo[2], hi[1], lo[1], hi[0], lo[0]};
   assign en   = s_q.cfg[5:0];
   assign mode = inertial_event_irq_two_pkg::combine_mode_t'(
                 {s_q.cfg[`IEV_CFG_COMBINE], s_q.cfg[`IEV_CFG_SIXDIR]});
   assign odr_tick = (s_q.div == ODR_DIV - 16'h0001);
   assign acc  = (avs_read || avs_write) && (s_q.bst == inertial_event_irq_two_pkg::BUS_IDLE);
   assign idx  = {2'b00, avs_address[7:2]};
   // read of the source register, taken once per access
   assign rd_src = acc && avs_read && (idx == `IEV_IDX_SOURCE);
   // in six-direction modes the direction is the enabled raw flags (raw & en), with no choice between the sides of an axis
   assign pos_now = raw & en;

   // mode decode of the qualifying condition
   always_comb begin
      cond = 1'b0;
      case (mode)
         inertial_event_irq_two_pkg::MODE_OR:   cond = |(raw & en);
         inertial_event_irq_two_pkg::MODE_AND:  cond = (en != `IEV_RST_FLAGS) && ((raw & en) == en);
         inertial_event_irq_two_pkg::MODE_MOVE: cond = |(pos_now & ~s_q.pos_q);
         // position: stable in a known enabled direction
         inertial_event_irq_two_pkg::MODE_POS:  cond = (pos_now != `IEV_RST_FLAGS) && (pos_now == s_q.pos_q);
         default:                               cond = 1'b0;
      endcase
   end

   // duration reached: zero duration fires at once on a tick with condition
   assign fire = cond && odr_tick && (s_q.cnt >= s_q.dur);

   ////////////////////////////////////////////////////////////////////////
   // next-state logic; bus answers one cycle after the request is seen
   always_comb begin
      s_d = s_q;
      avs_waitrequest = (s_q.bst == inertial_event_irq_two_pkg::BUS_IDLE);
      s_d.div = odr_tick ? `IEV_RST_DIV : s_q.div + 16'h0001;
      if (odr_tick) begin
         s_d.pos_q = pos_now;
         if (cond && !fire) begin
            s_d.cnt = (s_q.cnt == `IEV_CNT_MAX) ? s_q.cnt : s_q.cnt + 7'h01;
         end else if (!cond) begin
            s_d.cnt = `IEV_RST_FIELD;
         end
      end
      if (rd_src) begin
         s_d.active = 1'b0;
      end
      // event sets active; set wins over read clear
      if (fire) begin
         s_d.active = 1'b1;
         s_d.irq_st[`IEV_IRQ_EVENT] = 1'b1;
         if (!s_q.latch || !s_q.active || rd_src) begin
            s_d.flags = raw & en;
         end
      end
      // bus handshake
      if (s_q.bst == inertial_event_irq_two_pkg::BUS_DONE) begin
         s_d.bst = inertial_event_irq_two_pkg::BUS_IDLE;
      end else if (acc) begin
         s_d.bst   = inertial_event_irq_two_pkg::BUS_DONE;
         s_d.rdata = 32'h0000_0000;
         if (avs_read) begin
            case (idx)
               `IEV_IDX_CONFIG:     s_d.rdata[7:0] = s_q.cfg;
               `IEV_IDX_SOURCE:     s_d.rdata[7:0] = {1'b0, s_q.active, s_q.flags};
               `IEV_IDX_THRESHOLD:  s_d.rdata[7:0] = {1'b0, s_q.ths};
               `IEV_IDX_DURATION:   s_d.rdata[7:0] = {1'b0, s_q.dur};
               `IEV_IDX_IRQ_STATUS: s_d.rdata[`IEV_IRQ_WIDTH-1:0] = s_q.irq_st;
               `IEV_IDX_IRQ_MASK:   s_d.rdata[`IEV_IRQ_WIDTH-1:0] = s_q.irq_mk;
               `IEV_IDX_CONTROL:    s_d.rdata[`IEV_CTRL_LATCH] = s_q.latch;
               default:             s_d.rdata = 32'h0000_0000;
            endcase
         end else if (avs_byteenable[0]) begin
            case (idx)
               `IEV_IDX_CONFIG:     s_d.cfg = avs_writedata[7:0];
               `IEV_IDX_THRESHOLD:  s_d.ths = avs_writedata[`IEV_FIELD_MSB:0];
               `IEV_IDX_DURATION:   s_d.dur = avs_writedata[`IEV_FIELD_MSB:0];
               // write one to clear; a same-cycle event keeps the bit
               `IEV_IDX_IRQ_STATUS: s_d.irq_st = (s_q.irq_st & ~avs_writedata[`IEV_IRQ_WIDTH-1:0])
                                                 | (fire ? 1'b1 : 1'b0);
               `IEV_IDX_IRQ_MASK:   s_d.irq_mk = avs_writedata[`IEV_IRQ_WIDTH-1:0];
               `IEV_IDX_CONTROL:    s_d.latch = avs_writedata[`IEV_CTRL_LATCH];
               default:             s_d.cfg = s_q.cfg;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q.cfg    <= `IEV_RST_BYTE;
         s_q.ths    <= `IEV_RST_FIELD;
         s_q.dur    <= `IEV_RST_FIELD;
         s_q.latch  <= 1'b0;
         s_q.flags  <= `IEV_RST_FLAGS;
         s_q.active <= 1'b0;
         s_q.cnt    <= `IEV_RST_FIELD;
         s_q.div    <= `IEV_RST_DIV;
         s_q.irq_st <= '0;
         s_q.irq_mk <= '0;
         s_q.rdata  <= 32'h0000_0000;
         s_q.bst    <= inertial_event_irq_two_pkg::BUS_IDLE;
         s_q.pos_q  <= `IEV_RST_FLAGS;
      end else begin
         s_q <= s_d;
      end
   end

   assign event_pin_o  = s_q.active;
   assign irq_o        = |(s_q.irq_st & s_q.irq_mk);
   assign avs_readdata = s_q.rdata;

   ////////////////////////////////////////////////////////////////////////
   // assertions; all sample on the one system clock and sleep through reset
   // read clears pin
   AST_READ_CLEARS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_src && !fire |=> !event_pin_o)
      else $error("source read did not clear the active flag");

   AST_FIRE_SETS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      fire |=> event_pin_o && s_q.irq_st[`IEV_IRQ_EVENT])
      else $error("event did not set the active flag");

   AST_ACTIVE_ONLY_FIRE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !fire |=> !$rose(event_pin_o))
      else $error("active flag rose without an event");

   AST_PIN_HOLDS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      event_pin_o && !rd_src |=> event_pin_o)
      else $error("pin dropped without a source read");

   AST_SRC_MSB: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $past(rd_src) |-> !avs_readdata[7])
      else $error("source top bit not zero");

   AST_THS_MSB: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $past(acc && avs_read && idx == `IEV_IDX_THRESHOLD) |-> !avs_readdata[7])
      else $error("threshold top bit not zero");

   AST_DUR_MSB: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $past(acc && avs_read && idx == `IEV_IDX_DURATION) |-> !avs_readdata[7])
      else $error("duration top bit not zero");

   AST_LATCH_FROZEN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_q.latch && s_q.active && !rd_src |=> $stable(s_q.flags))
      else $error("latched flags changed before read");

   AST_EARLY_END: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      odr_tick && !cond |=> s_q.cnt == `IEV_RST_FIELD)
      else $error("count not restarted after early end");

   AST_FLAGS_ON_FIRE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !fire |=> $stable(s_q.flags))
      else $error("flags changed without an event");

   // nonzero duration needs history; the previous tick lies exactly one divider period back
   AST_NO_FIRE_SHORT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      fire && s_q.dur != `IEV_RST_FIELD |-> $past(cond && odr_tick, ODR_DIV))
      else $error("fired before minimum duration");

   AST_TICK_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !odr_tick |=> $stable(s_q.cnt))
      else $error("duration count moved between rate ticks");

   AST_OR_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      mode == inertial_event_irq_two_pkg::MODE_OR && (raw & en) == 6'h00 |-> !cond)
      else $error("or mode raised without enabled event");

   AST_AND_MODE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      mode == inertial_event_irq_two_pkg::MODE_AND && (raw & en) != en |-> !cond)
      else $error("and mode raised with an enabled event missing");

   AST_MOVE_NEW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      mode == inertial_event_irq_two_pkg::MODE_MOVE && pos_now == s_q.pos_q |-> !cond)
      else $error("movement raised without a new direction");

   AST_POS_STABLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      mode == inertial_event_irq_two_pkg::MODE_POS && pos_now != s_q.pos_q |-> !cond)
      else $error("position raised while direction changed");

   AST_HIGH_GATED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $changed(s_q.flags) |-> (s_q.flags & ~$past(en) & `IEV_HIGH_FLAGS) == `IEV_RST_FLAGS)
      else $error("disabled high event reached the flags");

   AST_LOW_GATED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      $changed(s_q.flags) |-> (s_q.flags & ~$past(en) & `IEV_LOW_FLAGS) == `IEV_RST_FLAGS)
      else $error("disabled low event reached the flags");

   AST_SRC_READ_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      acc && avs_write && idx == `IEV_IDX_SOURCE && !fire |=> $stable(s_q.flags) && $stable(s_q.active))
      else $error("write changed the source register");

   // status bit is sticky until a write of one
   AST_STATUS_STICKY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_q.irq_st[`IEV_IRQ_EVENT] && !(acc && avs_write && idx == `IEV_IDX_IRQ_STATUS)
      |=> s_q.irq_st[`IEV_IRQ_EVENT])
      else $error("interrupt status dropped without a clear");

   // a masked status never reaches the interrupt line
   AST_MASKED_QUIET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      !s_q.irq_mk[`IEV_IRQ_EVENT] |-> !irq_o)
      else $error("masked status raised the interrupt");

   // one wait cycle per access
   AST_WAIT_ONE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      acc |=> !avs_waitrequest)
      else $error("bus answer not after one cycle");

   // the answer stands for one cycle only, so a held request is not taken twice
   AST_WAIT_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      s_q.bst == inertial_event_irq_two_pkg::BUS_DONE |=> avs_waitrequest)
      else $error("bus answer stood longer than one cycle");

   // main scenarios worth seeing at least once
   COV_FIRE:  cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) fire);
   COV_CLEAR: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) event_pin_o ##1 rd_src);
   COV_AND:   cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      mode == inertial_event_irq_two_pkg::MODE_AND && fire);
   COV_POS:   cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      mode == inertial_event_irq_two_pkg::MODE_POS && fire);
   COV_MOVE:  cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      mode == inertial_event_irq_two_pkg::MODE_MOVE && fire);
endmodule
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [7:0]  A_CFG = 8'hD0;
   localparam logic [7:0]  A_SRC = 8'hD4;
   localparam logic [7:0]  A_THS = 8'hD8;
   localparam logic [7:0]  A_DUR = 8'hDC;
   localparam logic [7:0]  A_STS = 8'hE0;
   localparam logic [7:0]  A_MSK = 8'hE4;
   localparam logic [7:0]  A_CTL = 8'hE8;
   // threshold 8'h10 sits at 16'h1000, so these clear it by a factor of two
   localparam logic [15:0] HI    = 16'h2000;
   localparam logic [15:0] LO    = 16'hE000;
   logic        sys_clk_i      = 1'b0;
   logic        rst_n_i        = 1'b0;
   logic [47:0] accel_i        = 48'h0;
   logic [7:0]  avs_address    = 8'h00;
   logic        avs_read       = 1'b0;
   logic        avs_write      = 1'b0;
   logic [31:0] avs_writedata  = 32'h0;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        event_pin_o;
   logic        irq_o;
   logic        mask_on        = 1'b1;
   int          n_fail         = 0;
   int          check_count    = 0;

   // short data-rate divider keeps duration runs brief
   inertial_event_irq_two #(.WIDTH(16), .ODR_DIV(16'h0004)) uut (
      .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .accel_i(accel_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .event_pin_o(event_pin_o), .irq_o(irq_o));

   always #5 sys_clk_i = ~sys_clk_i;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   // one bus access; request held until waitrequest is sampled low
   task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge sys_clk_i);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_byteenable <= 4'hF;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus_xfer(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus_xfer(1'b0, a, 8'h00, q);
      chk(what, {24'h000000, e}, q);
   endtask

   task automatic set_acc(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      @(posedge sys_clk_i);
      accel_i <= {z, y, x};
   endtask

   // bounded wait: a missing event shows up as a failed compare
   task automatic wait_pin(input string what, input int max_cyc);
      int n;
      n = 0;
      while (event_pin_o !== 1'b1 && n < max_cyc) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk(what, 32'h1, {31'h0, event_pin_o});
   endtask

   task automatic stay_low(input string what, input int cyc);
      repeat (cyc) begin
         @(posedge sys_clk_i);
         chk(what, 32'h0, {31'h0, event_pin_o});
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // raise one event, drop the stimulus, then read and clear it
   task automatic fire(input logic [7:0] cfg, input logic [15:0] x, input logic [15:0] y,
                       input logic [15:0] z, input logic [7:0] src);
      wr(A_CFG, cfg);
      set_acc(x, y, z);
      wait_pin("pin set", 40);
      @(posedge sys_clk_i);
      chk("irq level", {31'h0, mask_on}, {31'h0, irq_o});
      set_acc(16'h0, 16'h0, 16'h0);
      repeat (12) @(posedge sys_clk_i);
      rd_chk("source flags", A_SRC, src);
      repeat (2) @(posedge sys_clk_i);
      stay_low("pin after read", 10);
      wr(A_STS, 8'h01);
      @(posedge sys_clk_i);
      chk("irq cleared", 32'h0, {31'h0, irq_o});
   endtask

   task automatic no_fire(input logic [7:0] cfg, input logic [15:0] x, input logic [15:0] y);
      wr(A_CFG, cfg);
      set_acc(x, y, 16'h0);
      stay_low("pin quiet", 30);
      set_acc(16'h0, 16'h0, 16'h0);
      repeat (8) @(posedge sys_clk_i);
   endtask

   task automatic reg_access();
      logic [7:0] adr [8] = '{A_CFG, A_SRC, A_THS, A_DUR, A_STS, A_MSK, A_CTL, 8'hFC};
      foreach (adr[i]) rd_chk("reset value", adr[i], 8'h00);
      wr(A_THS, 8'hFF);
      rd_chk("threshold", A_THS, 8'h7F);
      wr(A_DUR, 8'hFF);
      rd_chk("duration", A_DUR, 8'h7F);
      wr(A_CFG, 8'hA5);
      rd_chk("config", A_CFG, 8'hA5);
      wr(A_SRC, 8'hFF);
      rd_chk("source write", A_SRC, 8'h00);
      wr(A_THS, 8'h10);
      wr(A_DUR, 8'h00);
      wr(A_CTL, 8'h01);
      wr(A_MSK, 8'h01);
   endtask

   // every direction alone: low and high on x, y, z
   task automatic directions();
      logic [15:0] v;
      for (int i = 0; i < 6; i++) begin
         v = i[0] ? HI : LO;
         fire(8'h01 << i, (i / 2 == 0) ? v : 16'h0, (i / 2 == 1) ? v : 16'h0,
              (i / 2 == 2) ? v : 16'h0, 8'h40 | (8'h01 << i));
      end
   endtask

   // latched flags stay frozen until the source read
   task automatic latch_hold();
      wr(A_CFG, 8'h0A);
      set_acc(HI, 16'h0, 16'h0);
      wait_pin("latched set", 40);
      set_acc(16'h0, HI, 16'h0);
      repeat (12) @(posedge sys_clk_i);
      rd_chk("frozen flags", A_SRC, 8'h42);
      wait_pin("refill after read", 20);
      set_acc(16'h0, 16'h0, 16'h0);
      repeat (12) @(posedge sys_clk_i);
      rd_chk("refilled flags", A_SRC, 8'h48);
      // open mode: a later event refreshes the flags while still active
      wr(A_CTL, 8'h00);
      set_acc(HI, 16'h0, 16'h0);
      wait_pin("open set", 40);
      set_acc(16'h0, HI, 16'h0);
      repeat (12) @(posedge sys_clk_i);
      set_acc(16'h0, 16'h0, 16'h0);
      repeat (12) @(posedge sys_clk_i);
      rd_chk("open refresh", A_SRC, 8'h48);
      rd_chk("open after read", A_SRC, 8'h08);
      wr(A_CTL, 8'h01);
      wr(A_STS, 8'h01);
   endtask

   // four ticks with condition needed: two-tick bursts must never fire
   task automatic duration_test();
      wr(A_DUR, 8'h03);
      set_acc(HI, 16'h0, 16'h0);
      stay_low("short burst", 5);
      set_acc(16'h0, 16'h0, 16'h0);
      stay_low("burst gap", 7);
      set_acc(HI, 16'h0, 16'h0);
      stay_low("second burst", 5);
      set_acc(16'h0, 16'h0, 16'h0);
      stay_low("after bursts", 20);
      rd_chk("flags kept", A_SRC, 8'h08);
      wr(A_CFG, 8'h02);
      set_acc(HI, 16'h0, 16'h0);
      stay_low("before duration", 8);
      fire(8'h02, HI, 16'h0, 16'h0, 8'h42);
      wr(A_DUR, 8'h00);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (n_fail == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (6) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      reg_access();
      directions();
      no_fire(8'h01, HI, 16'h0);
      no_fire(8'h8A, HI, 16'h0);
      fire(8'h8A, HI, HI, 16'h0, 8'h4A);
      fire(8'h42, HI, 16'h0, 16'h0, 8'h42);
      fire(8'hC2, HI, 16'h0, 16'h0, 8'h42);
      latch_hold();
      duration_test();
      mask_on = 1'b0;
      wr(A_MSK, 8'h00);
      fire(8'h20, 16'h0, 16'h0, HI, 8'h60);
      print_verdict();
   end

   // hang guard, far beyond the under one thousand cycles the tests take
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_fail++;
      print_verdict();
   end
endmodule
`default_nettype wire
